/* File: hdl/tocu_top.sv */
// Timer output compare unit with APB register access
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "tocu_consts.svh"
// What this block does
// - A nonzero output mode field puts the channel's compare output on its pin, except PWM mode 01, which does so only for channel A at selections 14 and 15.
// - Outside PWM, a match does nothing, toggles, clears or sets for modes 00, 01, 10, 11.
// - In fast PWM mode 01 only channel A toggles, and only for selections 14 and 15.
// - In fast PWM mode 10 the output clears on match and sets at bottom.
// - In fast PWM mode 11 the output sets on match and clears at bottom.
// - Compare values are double buffered in PWM modes and written directly otherwise.
// - Buffered compare values move to the active register only at top or bottom.
// - Software reaches the buffer when buffering and the active register otherwise.
// - Outside PWM the force strobe updates the output as a real match would.
// - A forced compare touches neither the match flag nor the counter.
// - A counter write blocks any match in the next timer tick, even while stopped.
// - The compare output keeps its value across waveform mode changes.
// - Output mode changes take effect at once, with no buffering.
module tocu_top
   import tocu_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output tocu_pin_t pin_a,
   output tocu_pin_t pin_b
);

   function automatic tocu_wf_t wf_class(input logic [3:0] ws);
      if (ws == 4'h0)
      begin
         return TOCU_WF_NORMAL;
      end
      if (ws == `TOCU_WS_CTC_OCR || ws == `TOCU_WS_CTC_ALT)
      begin
         return TOCU_WF_CTC;
      end
      return TOCU_WF_PWM;
   endfunction : wf_class

   // Next compare output level; bottom outranks a match landing on the same tick
   function automatic logic oc_next(input logic oc, input logic [1:0] m, input tocu_wf_t wf,
                                    input logic tog_ok, input logic match, input logic bottom,
                                    input logic frc);
      logic r;
      r = oc;
      if (wf != TOCU_WF_PWM)
      begin
         if (match || frc)
         begin
            case (m)
               2'b01: r = !oc;
               2'b10: r = 1'b0;
               2'b11: r = 1'b1;
               default: r = oc;
            endcase
         end
      end
      else
      begin
         if (m == 2'b01 && tog_ok && match)
         begin
            r = !oc;
         end
         if (m[1] && match)
         begin
            r = m[0];
         end
         if (m[1] && bottom)
         begin
            r = !m[0];
         end
      end
      return r;
   endfunction : oc_next

   function automatic logic oc_conn(input logic [1:0] m, input tocu_wf_t wf,
                                    input logic tog_ok);
      if (wf == TOCU_WF_PWM && m == 2'b01)
      begin
         return tog_ok;
      end
      return m != 2'b00;
   endfunction : oc_conn

   logic [7:0] ctrl_a_r, ctrl_a_nxt;
   logic [7:0] ctrl_b_r, ctrl_b_nxt;
   logic [3:0] port_r, port_nxt;
   tocu_timer_t tm_r, tm_nxt;
   logic [7:0] presc_r, presc_nxt;
   logic block_r, block_nxt;
   logic flag_a_r, flag_a_nxt, flag_b_r, flag_b_nxt;
   logic oc_a_r, oc_a_nxt, oc_b_r, oc_b_nxt;
   logic [31:0] prdata_r, prdata_nxt;

   logic [3:0] ws;
   tocu_wf_t wf;
   logic buffered, tog_ok_a, tick, wrap, match_a, match_b, conn_a, conn_b;
   logic wr, setup, hit, force_a, force_b;
   logic [7:0] top, cmp_a_vis, cmp_b_vis;

   assign ws = {ctrl_b_r[`TOCU_WS_HI_HI:`TOCU_WS_HI_LO], ctrl_a_r[`TOCU_WS_LO_HI:`TOCU_WS_LO_LO]};
   assign wf = wf_class(ws);
   assign buffered = (wf == TOCU_WF_PWM);
   assign tog_ok_a = (ws == `TOCU_WS_FAST_ALT || ws == `TOCU_WS_FAST_OCR);
   assign top = (wf == TOCU_WF_CTC || ws == `TOCU_WS_FAST_OCR) ? tm_r.cmp_a : `TOCU_CNT_MAX;
   assign tick = ctrl_b_r[`TOCU_RUN_BIT] && (presc_r == 8'h00);
   assign wrap = tick && (tm_r.cnt == top);
   assign match_a = tick && !block_r && (tm_r.cnt == tm_r.cmp_a);
   assign match_b = tick && !block_r && (tm_r.cnt == tm_r.cmp_b);
   assign conn_a = oc_conn(ctrl_a_r[`TOCU_MODE_A_HI:`TOCU_MODE_A_LO], wf, tog_ok_a);
   assign conn_b = oc_conn(ctrl_a_r[`TOCU_MODE_B_HI:`TOCU_MODE_B_LO], wf, 1'b0);
   assign cmp_a_vis = buffered ? tm_r.buf_a : tm_r.cmp_a;
   assign cmp_b_vis = buffered ? tm_r.buf_b : tm_r.cmp_b;

   assign wr = psel && penable && pwrite;
   assign setup = psel && !penable;
   assign hit = (paddr == `TOCU_OFS_CTRL_A) || (paddr == `TOCU_OFS_CTRL_B) ||
                (paddr == `TOCU_OFS_COUNT) || (paddr == `TOCU_OFS_CMP_A) ||
                (paddr == `TOCU_OFS_CMP_B) || (paddr == `TOCU_OFS_STATUS) ||
                (paddr == `TOCU_OFS_PORT);
   // Forcing has no meaning in PWM modes, so the strobe is dropped there
   assign force_a = wr && paddr == `TOCU_OFS_CTRL_B && pwdata[`TOCU_FORCE_A_BIT] &&
                    wf != TOCU_WF_PWM;
   assign force_b = wr && paddr == `TOCU_OFS_CTRL_B && pwdata[`TOCU_FORCE_B_BIT] &&
                    wf != TOCU_WF_PWM;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_r;
   assign pin_a.oe = port_r[`TOCU_DIR_A_BIT];
   assign pin_b.oe = port_r[`TOCU_DIR_B_BIT];
   assign pin_a.out = conn_a ? oc_a_r : port_r[`TOCU_VAL_A_BIT];
   assign pin_b.out = conn_b ? oc_b_r : port_r[`TOCU_VAL_B_BIT];

   always_comb
   begin
      ctrl_a_nxt = ctrl_a_r;
      ctrl_b_nxt = ctrl_b_r;
      port_nxt = port_r;
      tm_nxt = tm_r;
      block_nxt = block_r;
      presc_nxt = presc_r;
      prdata_nxt = prdata_r;
      if (ctrl_b_r[`TOCU_RUN_BIT])
      begin
         presc_nxt = (presc_r == `TOCU_PRESC_DIV - 8'h01) ? 8'h00 : presc_r + 8'h01;
      end
      if (tick)
      begin
         block_nxt = 1'b0;
         tm_nxt.cnt = wrap ? 8'h00 : tm_r.cnt + 8'h01;
         if (wrap && buffered)
         begin
            tm_nxt.cmp_a = tm_r.buf_a;
            tm_nxt.cmp_b = tm_r.buf_b;
         end
      end
      // Flags: a hardware set wins over a software clear in the same cycle
      flag_a_nxt = (flag_a_r && !(wr && paddr == `TOCU_OFS_STATUS &&
                   pwdata[`TOCU_FLAG_A_BIT])) || match_a;
      flag_b_nxt = (flag_b_r && !(wr && paddr == `TOCU_OFS_STATUS &&
                   pwdata[`TOCU_FLAG_B_BIT])) || match_b;
      // Mode changes never reload the output register
      oc_a_nxt = oc_next(oc_a_r, ctrl_a_r[`TOCU_MODE_A_HI:`TOCU_MODE_A_LO], wf, tog_ok_a,
                         match_a, wrap, force_a);
      oc_b_nxt = oc_next(oc_b_r, ctrl_a_r[`TOCU_MODE_B_HI:`TOCU_MODE_B_LO], wf, 1'b0,
                         match_b, wrap, force_b);
      if (wr)
      begin
         case (paddr)
            `TOCU_OFS_CTRL_A: ctrl_a_nxt = pwdata[7:0] & 8'hF3;
            `TOCU_OFS_CTRL_B: ctrl_b_nxt = pwdata[7:0] & 8'h07;
            `TOCU_OFS_PORT: port_nxt = pwdata[3:0];
            `TOCU_OFS_COUNT:
            begin
               tm_nxt.cnt = pwdata[7:0];
               block_nxt = 1'b1;
            end
            `TOCU_OFS_CMP_A:
            begin
               tm_nxt.buf_a = pwdata[7:0];
               if (!buffered)
               begin
                  tm_nxt.cmp_a = pwdata[7:0];
               end
            end
            `TOCU_OFS_CMP_B:
            begin
               tm_nxt.buf_b = pwdata[7:0];
               if (!buffered)
               begin
                  tm_nxt.cmp_b = pwdata[7:0];
               end
            end
            default: ;
         endcase
      end
      // Read data is captured in the setup cycle so prdata comes from a flip-flop
      if (setup && !pwrite)
      begin
         case (paddr)
            `TOCU_OFS_CTRL_A: prdata_nxt = {24'h00_0000, ctrl_a_r};
            `TOCU_OFS_CTRL_B: prdata_nxt = {24'h00_0000, ctrl_b_r};
            `TOCU_OFS_COUNT: prdata_nxt = {24'h00_0000, tm_r.cnt};
            `TOCU_OFS_CMP_A: prdata_nxt = {24'h00_0000, cmp_a_vis};
            `TOCU_OFS_CMP_B: prdata_nxt = {24'h00_0000, cmp_b_vis};
            `TOCU_OFS_STATUS: prdata_nxt = {28'h000_0000, oc_b_r, oc_a_r, flag_b_r, flag_a_r};
            `TOCU_OFS_PORT: prdata_nxt = {28'h000_0000, port_r};
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_a_r <= `TOCU_CTRL_A_RST;
         ctrl_b_r <= `TOCU_CTRL_B_RST;
         port_r <= `TOCU_PORT_RST;
         tm_r <= {`TOCU_CNT_RST, `TOCU_CMP_RST, `TOCU_CMP_RST, `TOCU_CMP_RST, `TOCU_CMP_RST};
         presc_r <= 8'h00;
         block_r <= 1'b0;
         flag_a_r <= 1'b0;
         flag_b_r <= 1'b0;
         oc_a_r <= 1'b0;
         oc_b_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         ctrl_a_r <= ctrl_a_nxt;
         ctrl_b_r <= ctrl_b_nxt;
         port_r <= port_nxt;
         tm_r <= tm_nxt;
         presc_r <= presc_nxt;
         block_r <= block_nxt;
         flag_a_r <= flag_a_nxt;
         flag_b_r <= flag_b_nxt;
         oc_a_r <= oc_a_nxt;
         oc_b_r <= oc_b_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_cnt_write;
      wr && paddr == `TOCU_OFS_COUNT;
   endsequence
   sequence s_blocked_tick;
      block_r && tick;
   endsequence

   property p_conn_a;
      ctrl_a_r[7:6] != 2'b00 && wf != TOCU_WF_PWM |-> pin_a.out == oc_a_r;
   endproperty
   a_conn_a: assert property (p_conn_a) else $error("channel A not routed to pin");
   property p_oe;
      pin_a.oe == port_r[0] && pin_b.oe == port_r[1];
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable differs from direction bit");
   property p_nonpwm_clear;
      match_a && wf != TOCU_WF_PWM && ctrl_a_r[7:6] == 2'b10 |=> !oc_a_r;
   endproperty
   a_nonpwm_clear: assert property (p_nonpwm_clear) else $error("clear on match failed");
   property p_nonpwm_toggle;
      match_a && wf != TOCU_WF_PWM && ctrl_a_r[7:6] == 2'b01 |=> oc_a_r != $past(oc_a_r);
   endproperty
   a_nonpwm_toggle: assert property (p_nonpwm_toggle) else $error("toggle failed");
   property p_pwm01_b;
      wf == TOCU_WF_PWM && ctrl_a_r[5:4] == 2'b01 |-> pin_b.out == port_r[3];
   endproperty
   a_pwm01_b: assert property (p_pwm01_b) else $error("channel B connected in mode 01");
   property p_pwm_bottom;
      wrap && wf == TOCU_WF_PWM && ctrl_a_r[7:6] == 2'b10 |=> oc_a_r;
   endproperty
   a_pwm_bottom: assert property (p_pwm_bottom) else $error("not set at bottom");
   property p_pwm_inv;
      match_a && !wrap && wf == TOCU_WF_PWM && ctrl_a_r[7:6] == 2'b11 |=> oc_a_r;
   endproperty
   a_pwm_inv: assert property (p_pwm_inv) else $error("inverting match not set");
   property p_direct_cmp;
      wr && paddr == `TOCU_OFS_CMP_A && !buffered |=> tm_r.cmp_a == $past(pwdata[7:0]);
   endproperty
   a_direct_cmp: assert property (p_direct_cmp) else $error("direct write lost");
   property p_buf_update;
      $changed(tm_r.cmp_a) && $past(buffered) |-> $past(wrap);
   endproperty
   a_buf_update: assert property (p_buf_update) else $error("compare moved off top");
   property p_force_clear;
      force_a && ctrl_a_r[7:6] == 2'b10 && !match_a |=> !oc_a_r ##0 flag_a_r == $past(flag_a_r);
   endproperty
   a_force_clear: assert property (p_force_clear) else $error("force misbehaved");
   property p_block;
      s_cnt_write |=> block_r and (s_blocked_tick |-> !match_a && !match_b);
   endproperty
   a_block: assert property (p_block) else $error("match not blocked");
   property p_mode_now;
      wr && paddr == `TOCU_OFS_CTRL_A |=> ctrl_a_r[7:4] == $past(pwdata[7:4]);
   endproperty
   a_mode_now: assert property (p_mode_now) else $error("mode write delayed");
   property p_match_flag;
      tick && !block_r && tm_r.cnt == tm_r.cmp_a |=> flag_a_r;
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match flag not set");

endmodule : tocu_top

/* File: hdl/tocu_consts.svh */
// Register offsets, field positions, reset values and timing counts of the compare unit
`ifndef TOCU_CONSTS_SVH
`define TOCU_CONSTS_SVH

`define TOCU_OFS_CTRL_A 8'h00
`define TOCU_OFS_CTRL_B 8'h04
`define TOCU_OFS_COUNT 8'h08
`define TOCU_OFS_CMP_A 8'h0C
`define TOCU_OFS_CMP_B 8'h10
`define TOCU_OFS_STATUS 8'h14
`define TOCU_OFS_PORT 8'h18

`define TOCU_CTRL_A_RST 8'h00
`define TOCU_CTRL_B_RST 8'h00
`define TOCU_PORT_RST 4'h0
`define TOCU_CNT_RST 8'h00
`define TOCU_CMP_RST 8'h00

`define TOCU_MODE_A_HI 7
`define TOCU_MODE_A_LO 6
`define TOCU_MODE_B_HI 5
`define TOCU_MODE_B_LO 4
`define TOCU_WS_LO_HI 1
`define TOCU_WS_LO_LO 0
`define TOCU_WS_HI_HI 1
`define TOCU_WS_HI_LO 0
`define TOCU_RUN_BIT 2
`define TOCU_FORCE_A_BIT 4
`define TOCU_FORCE_B_BIT 5
`define TOCU_FLAG_A_BIT 0
`define TOCU_FLAG_B_BIT 1
`define TOCU_OC_A_BIT 2
`define TOCU_OC_B_BIT 3
`define TOCU_DIR_A_BIT 0
`define TOCU_DIR_B_BIT 1
`define TOCU_VAL_A_BIT 2
`define TOCU_VAL_B_BIT 3

`define TOCU_WS_CTC_OCR 4'h4
`define TOCU_WS_CTC_ALT 4'hC
`define TOCU_WS_FAST_ALT 4'hE
`define TOCU_WS_FAST_OCR 4'hF
`define TOCU_CNT_MAX 8'hFF

// Timer tick every this many mclk cycles while running
`define TOCU_PRESC_DIV 8'h08

`endif

/* File: hdl/tocu_pkg.sv */
// Types shared by the compare unit
package tocu_pkg;

   typedef enum logic [1:0] {
      TOCU_WF_NORMAL = 2'b00,
      TOCU_WF_CTC = 2'b01,
      TOCU_WF_PWM = 2'b11
   } tocu_wf_t;

   typedef struct packed {
      logic out;
      logic oe;
   } tocu_pin_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic [7:0] buf_a;
      logic [7:0] buf_b;
   } tocu_timer_t;

endpackage : tocu_pkg

/* File: bench/tocu_top_tb.sv */
// Self-checking testbench of the timer output compare unit
`timescale 1ns/1ps
`include "tocu_consts.svh"
module tocu_top_tb
   import tocu_pkg::*;
;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic e;
   } tocu_row_t;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   tocu_pin_t pin_a;
   tocu_pin_t pin_b;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   logic [31:0] q;
   logic e;
   logic e1;
   tocu_row_t rows [9];
   logic [1:0] fmode [4];
   logic [3:0] foc [4];
   tocu_top dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_a(pin_a), .pin_b(pin_b));
   initial
   begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask : chk
   // Bus master: request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rq, output logic re);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         chk("pready", 32'h0000_0001, 32'h0000_0000);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(nm, exp, q);
   endtask : rdc
   // One extra edge lets register updates reach the combinational pin mux
   task automatic pin_chk(input logic [1:0] ea, input logic [1:0] eb);
      @(posedge mclk);
      #1;
      chk("pin_a", {30'h0, ea}, {30'h0, pin_a});
      chk("pin_b", {30'h0, eb}, {30'h0, pin_b});
   endtask : pin_chk
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask : idle
   initial
   begin
      rows = '{'{`TOCU_OFS_CMP_B, 32'h0000_005A, 32'h0000_005A, 1'b0},
         '{`TOCU_OFS_COUNT, 32'h0000_0021, 32'h0000_0021, 1'b0},
         '{`TOCU_OFS_CTRL_A, 32'h0000_00FF, 32'h0000_00F3, 1'b0},
         '{`TOCU_OFS_CTRL_A, 32'h0000_0000, 32'h0000_0000, 1'b0},
         '{`TOCU_OFS_CTRL_B, 32'h0000_0033, 32'h0000_0003, 1'b0},
         '{`TOCU_OFS_CTRL_B, 32'h0000_0000, 32'h0000_0000, 1'b0},
         '{`TOCU_OFS_PORT, 32'h0000_000C, 32'h0000_000C, 1'b0},
         '{8'h1C, 32'h0000_00FF, 32'h0000_0000, 1'b1},
         '{`TOCU_OFS_STATUS, 32'h0000_0003, 32'h0000_0000, 1'b0}};
      fmode = '{2'b11, 2'b10, 2'b01, 2'b01};
      foc = '{4'h4, 4'h0, 4'h4, 4'h0};
      idle(16);
      rst_b <= 1'b1;
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].d, q, e1);
         apb(1'b0, rows[i].a, 32'h0000_0000, q, e);
         chk("reg", rows[i].q, q);
         chk("pslverr wr", {31'h0, rows[i].e}, {31'h0, e1});
         chk("pslverr rd", {31'h0, rows[i].e}, {31'h0, e});
      end
      $display("Test rows done");
      // Stopped normal mode: each force acts as a match would
      wr(`TOCU_OFS_COUNT, 32'h0000_0033);
      for (int i = 0; i < 4; i++)
      begin
         wr(`TOCU_OFS_CTRL_A, {24'h0, fmode[i], 6'h00});
         wr(`TOCU_OFS_CTRL_B, 32'h0000_0010);
         rdc("force status", `TOCU_OFS_STATUS, {28'h0, foc[i]});
      end
      rdc("force count", `TOCU_OFS_COUNT, 32'h0000_0033);
      $display("Test force done");
      wr(`TOCU_OFS_PORT, 32'h0000_0005);
      wr(`TOCU_OFS_CTRL_A, 32'h0000_0000);
      pin_chk(2'b11, 2'b00);
      wr(`TOCU_OFS_CTRL_A, 32'h0000_0080);
      pin_chk(2'b01, 2'b00);
      $display("Test pin done");
      // A counter write hides the match on the following tick only
      wr(`TOCU_OFS_CTRL_A, 32'h0000_00C0);
      wr(`TOCU_OFS_CMP_A, 32'h0000_0005);
      wr(`TOCU_OFS_COUNT, 32'h0000_0005);
      wr(`TOCU_OFS_CTRL_B, 32'h0000_0004);
      idle(12);
      wr(`TOCU_OFS_CTRL_B, 32'h0000_0000);
      rdc("blocked", `TOCU_OFS_STATUS, 32'h0000_0000);
      wr(`TOCU_OFS_COUNT, 32'h0000_0004);
      wr(`TOCU_OFS_CTRL_B, 32'h0000_0004);
      idle(12);
      wr(`TOCU_OFS_CTRL_B, 32'h0000_0000);
      rdc("match", `TOCU_OFS_STATUS, 32'h0000_0005);
      wr(`TOCU_OFS_STATUS, 32'h0000_0003);
      $display("Test block done");
      // Selection 5 is PWM with top 0xFF; the buffered value 3 only lands at the wrap
      for (int m = 2; m < 4; m++)
      begin
         wr(`TOCU_OFS_CTRL_A, 32'h0000_0000);
         wr(`TOCU_OFS_CMP_A, 32'h0000_0040);
         wr(`TOCU_OFS_CTRL_A, {24'h0, m[1:0], 6'h01});
         wr(`TOCU_OFS_CTRL_B, 32'h0000_0001);
         wr(`TOCU_OFS_CMP_A, 32'h0000_0003);
         wr(`TOCU_OFS_COUNT, 32'h0000_0002);
         wr(`TOCU_OFS_CTRL_B, 32'h0000_0005);
         idle(12);
         wr(`TOCU_OFS_CTRL_B, 32'h0000_0001);
         // Output A enters each pass opposite to what an early load at 3 would leave
         rdc("buffered", `TOCU_OFS_STATUS, {29'h0, m == 2, 2'b00});
         wr(`TOCU_OFS_COUNT, 32'h0000_00FE);
         wr(`TOCU_OFS_CTRL_B, 32'h0000_0005);
         idle(16);
         rdc("bottom", `TOCU_OFS_STATUS, {29'h0, m == 2, 2'b00});
         idle(26);
         rdc("pwm match", `TOCU_OFS_STATUS, {29'h0, m == 3, 2'b01});
         wr(`TOCU_OFS_CTRL_B, 32'h0000_0000);
         wr(`TOCU_OFS_CTRL_A, {24'h0, m[1:0], 6'h00});
         rdc("mode change", `TOCU_OFS_STATUS, {29'h0, m == 3, 2'b01});
         wr(`TOCU_OFS_STATUS, 32'h0000_0003);
      end
      $display("Test pwm done");
      // Output A ends high and output B low; port values differ from them so a wrong mux shows
      wr(`TOCU_OFS_PORT, 32'h0000_000B);
      wr(`TOCU_OFS_CTRL_A, 32'h0000_0051);
      wr(`TOCU_OFS_CTRL_B, 32'h0000_0001);
      pin_chk(2'b01, 2'b11);
      wr(`TOCU_OFS_CTRL_A, 32'h0000_0053);
      wr(`TOCU_OFS_CTRL_B, 32'h0000_0003);
      pin_chk(2'b11, 2'b11);
      // Selection 15 with top equal to compare A: one match toggles output A low
      wr(`TOCU_OFS_COUNT, 32'h0000_0002);
      wr(`TOCU_OFS_CTRL_B, 32'h0000_0007);
      idle(20);
      wr(`TOCU_OFS_CTRL_B, 32'h0000_0003);
      pin_chk(2'b01, 2'b11);
      $display("Test sel done");
      @(posedge mclk);
      rst_b <= 1'b0;
      pin_chk(2'b00, 2'b00);
      idle(2);
      rst_b <= 1'b1;
      rdc("ctrl_a reset", `TOCU_OFS_CTRL_A, 32'h0000_0000);
      rdc("port reset", `TOCU_OFS_PORT, 32'h0000_0000);
      $display("Test reset done");
      close_out();
   end
endmodule : tocu_top_tb
